// File: core/ocw_pkg.sv
// package for the option, clock and watchdog configuration block
// assumes a single core clock and a synchronous active-high reset
package ocw_pkg;

    // apb register byte offsets
    localparam logic [7:0] OCW_STATUS_OFS  = 8'h00;
    localparam logic [7:0] OCW_MASK_OFS    = 8'h04;
    localparam logic [7:0] OCW_OPTION_OFS  = 8'h08;
    localparam logic [7:0] OCW_WDCLR_OFS   = 8'h0C;
    localparam logic [7:0] OCW_GPIO_OFS    = 8'h10;
    localparam logic [7:0] OCW_PROGRAM_FLAG_REGISTER_OFS   = 8'h14;

    // status / mask bit positions
    localparam int OCW_EV_WDT   = 0;
    localparam int OCW_EV_EXT   = 1;
    localparam int OCW_EV_BOR   = 2;
    localparam int OCW_EV_MID   = 3;
    localparam int OCW_EV_HIGH  = 4;
    localparam int OCW_EV_W     = 5;

    // gpio register bit positions
    localparam int OCW_GPIO_OUT = 0;
    localparam int OCW_GPIO_OE  = 1;
    localparam int OCW_GPIO_IN  = 2;

    // reset values
    localparam logic [4:0] OCW_MASK_RST = 5'h00;
    localparam logic [1:0] OCW_GPIO_RST = 2'h0;

    // watchdog counter width and prescale base (losc/4 at select 0)
    localparam int         OCW_WDT_W    = 8;
    localparam logic [5:0] OCW_WDT_BASE = 6'h04;

    // operating modes
    localparam logic [1:0] OCW_MODE_NORMAL = 2'h0;
    localparam logic [1:0] OCW_MODE_SLOW   = 2'h1;
    localparam logic [1:0] OCW_MODE_SLEEP  = 2'h2;
    localparam logic [1:0] OCW_MODE_GREEN  = 2'h3;

    // watchdog policies
    localparam logic [1:0] OCW_WDT_OFF    = 2'h0;
    localparam logic [1:0] OCW_WDT_ENABLE = 2'h1;
    localparam logic [1:0] OCW_WDT_ALWAYS = 2'h2;

    // brown-out levels
    localparam logic [1:0] OCW_BOR_LOW  = 2'h0;
    localparam logic [1:0] OCW_BOR_MID  = 2'h1;
    localparam logic [1:0] OCW_BOR_HIGH = 2'h2;
    localparam logic [1:0] OCW_BOR_MAX  = 2'h3;

    // fixed hardware options, caught during reset
    typedef struct packed {
        logic [2:0] highDiv;      // normal mode: 2**n high clocks
        logic [1:0] lowDiv;       // slow mode: 2**n low clocks
        logic [1:0] watchdogClockSelect; // 4 << n low clocks
        logic [1:0] watchdogPolicy;
        logic       sharedIoPinMode;     // 1 = gpio, 0 = external reset
        logic       codeProtect;
        logic [1:0] brownoutLevel;
    } ocw_option_type;

    // voltage detector outputs, high when supply is below threshold
    typedef struct packed {
        logic below30;
        logic below23;
        logic below18;
    } ocw_detect_type;

endpackage : ocw_pkg

// File: core/ocw_option_clock.sv
// option decode, instruction-cycle dividers, watchdog and brown-out logic
// assumes oscillators, pin and detectors arrive asynchronously to core_clk
// What this block does
// [RULE_01] normal mode divides high oscillator by 8, 16, 32, 64 or 128
// [RULE_02] normal mode also offers divide by 1, 2 and 4
// [RULE_03] slow mode divides low oscillator by 1, 2, 4 or 8
// [RULE_04] watchdog ticks from low oscillator divided by 4, 8, 16 or 32
// [RULE_05] always-run watchdog counts in every mode, sleep and green included
// [RULE_06] enabled watchdog counts in active modes, halts in sleep and green
// [RULE_07] disabled watchdog never runs and never resets
// [RULE_08] option picks external reset or gpio for the shared pin
// [RULE_09] in reset mode a falling pin edge resets the device
// [RULE_10] option enables program-memory code protection
// [RULE_11] protected code is never dumped through the readout path
// [RULE_12] low level resets chip when supply is below 1.8 V
// [RULE_13] mid level shows the 2.3 V flag in the program flag register
// [RULE_14] high level resets chip when supply is below 2.3 V
// [RULE_15] high level shows the 3.0 V flag in the program flag register
// [RULE_16] options are caught during reset and held until the next one
module ocw_option_clock
    import ocw_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // fixed options and operating mode
    input  wire ocw_option_type       optionIn,
    input  wire logic [1:0]           opMode,
    // asynchronous sources
    input  wire logic                 highOscIn,
    input  wire logic                 lowOscIn,
    input  wire ocw_detect_type       detectIn,
    // shared pin
    input  wire logic                 sharedPinIn,
    output logic                      sharedPinOut,
    output logic                      sharedPinOe,
    // instruction cycle and resets
    output logic                      cpuTick,
    output logic                      chipReset,
    // readout path
    input  wire logic                 readoutValidIn,
    input  wire logic [15:0]          readoutDataIn,
    output logic                      readoutValid,
    output logic [15:0]               readoutData,
    // low-supply indicator bits
    output logic                      lowSupplyFlagMid,
    output logic                      lowSupplyFlagHigh,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // interrupt
    output logic                      irq
);

    localparam int NSYNC = 6;

    ocw_option_type         opt;
    logic [NSYNC-1:0]       asyncIn;
    logic [NSYNC-1:0]       syncLevel;
    logic [NSYNC-1:0]       syncRise;
    logic [NSYNC-1:0]       syncFall;
    logic [6:0]             highCnt;
    logic [2:0]             lowCnt;
    logic [4:0]             wdtPreCnt;
    logic [OCW_WDT_W-1:0]   wdtCnt;
    logic [OCW_EV_W-1:0]    status;
    logic [OCW_EV_W-1:0]    mask;
    logic [1:0]             gpio;
    logic                   flagMidPrev;
    logic                   flagHighPrev;

    // collect asynchronous inputs for the synchroniser bank
    assign asyncIn = {detectIn.below30, detectIn.below23,
                      detectIn.below18, sharedPinIn, lowOscIn, highOscIn};

    // three-stage synchronisers; a change counts once stages two and
    // three agree, which rejects a single metastable sample
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            logic [2:0] stage;
            logic       agree;
            assign agree        = stage[1] == stage[2];
            assign syncRise[gi] = agree & stage[2] & ~syncLevel[gi];
            assign syncFall[gi] = agree & ~stage[2] & syncLevel[gi];
            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    stage          <= 3'h0;
                    syncLevel[gi]  <= 1'b0;
                end
                else
                begin
                    stage <= {stage[1:0], asyncIn[gi]};
                    if (agree)
                        syncLevel[gi] <= stage[2];
                end
            end
        end
    endgenerate

    wire highEdge = syncRise[0];
    wire lowEdge  = syncRise[1];
    wire pinFall  = syncFall[2];
    wire below18  = syncLevel[3];
    wire below23  = syncLevel[4];
    wire below30  = syncLevel[5];

    // options are sampled only while reset is held, so nothing moves
    // underneath running logic
    always_ff @(posedge core_clk)
    begin
        if (srst)
            opt <= optionIn; // [RULE_16]
    end

    // divider limits: ratio minus one, all powers of two
    wire [6:0] highLimit = 7'((8'h01 << opt.highDiv) - 8'h01); // [RULE_01] [RULE_02]
    wire [2:0] lowLimit  = 3'((4'h1 << opt.lowDiv) - 4'h1);    // [RULE_03]
    wire [4:0] wdtLimit  =
        5'((OCW_WDT_BASE << opt.watchdogClockSelect) - 6'h01); // [RULE_04]

    wire modeNormal = opMode == OCW_MODE_NORMAL;
    wire modeSlow   = opMode == OCW_MODE_SLOW;
    wire modeActive = modeNormal | modeSlow;

    wire highWrap = highEdge & (highCnt == highLimit);
    wire lowWrap  = lowEdge & (lowCnt == lowLimit);
    wire wdtPreWrap = lowEdge & (wdtPreCnt == wdtLimit);

    // watchdog run policy
    wire wdtRun =
        (opt.watchdogPolicy == OCW_WDT_ALWAYS) |              // [RULE_05]
        ((opt.watchdogPolicy == OCW_WDT_ENABLE) & modeActive); // [RULE_06]
    wire wdtOff  = (opt.watchdogPolicy != OCW_WDT_ALWAYS) &
                   (opt.watchdogPolicy != OCW_WDT_ENABLE);     // [RULE_07]
    wire wdtFire = wdtRun & wdtPreWrap & (&wdtCnt);

    // shared pin decode
    wire pinIsGpio  = opt.sharedIoPinMode;                     // [RULE_08]
    wire extResetEv = ~pinIsGpio & pinFall;                    // [RULE_09]

    // brown-out decode; mid level still guards the 1.8 V floor
    wire borEv =
        (below18 & (opt.brownoutLevel != OCW_BOR_HIGH) &
         (opt.brownoutLevel != OCW_BOR_MAX)) |                 // [RULE_12]
        (below23 & (opt.brownoutLevel == OCW_BOR_HIGH)) |      // [RULE_14]
        (below30 & (opt.brownoutLevel == OCW_BOR_MAX));
    wire flagMid  = (opt.brownoutLevel == OCW_BOR_MID) & below23;  // [RULE_13]
    wire flagHigh = (opt.brownoutLevel == OCW_BOR_HIGH) & below30; // [RULE_15]

    // apb decode; zero wait states, read data staged in the setup cycle
    wire apbSetup  = psel & ~penable;
    wire apbAccess = psel & penable;
    wire hitStatus = paddr == OCW_STATUS_OFS;
    wire hitMask   = paddr == OCW_MASK_OFS;
    wire hitOption = paddr == OCW_OPTION_OFS;
    wire hitWdClr  = paddr == OCW_WDCLR_OFS;
    wire hitGpio   = paddr == OCW_GPIO_OFS;
    wire hitPflag  = paddr == OCW_PROGRAM_FLAG_REGISTER_OFS;
    wire hitAny    = hitStatus | hitMask | hitOption | hitWdClr |
                     hitGpio | hitPflag;
    wire wrEn      = apbAccess & pwrite & hitAny;
    wire wdtKick   = wrEn & hitWdClr & pwdata[0];

    wire [OCW_EV_W-1:0] events;
    assign events[OCW_EV_WDT]  = wdtFire;
    assign events[OCW_EV_EXT]  = extResetEv;
    assign events[OCW_EV_BOR]  = borEv;
    assign events[OCW_EV_MID]  = flagMid & ~flagMidPrev;
    assign events[OCW_EV_HIGH] = flagHigh & ~flagHighPrev;

    // write-one-to-clear; an event in the clearing cycle survives
    wire [OCW_EV_W-1:0] w1c = (wrEn & hitStatus) ?
                              pwdata[OCW_EV_W-1:0] : '0;
    wire [OCW_EV_W-1:0] next_status = (status & ~w1c) | events;

    wire [31:0] readMux =
        hitStatus ? {27'h0, status} :
        hitMask   ? {27'h0, mask} :
        hitOption ? {19'h0, opt} :
        hitGpio   ? {29'h0, syncLevel[2], gpio} :
        hitPflag  ? {30'h0, lowSupplyFlagHigh, lowSupplyFlagMid} :
                    32'h0;

    assign pready  = 1'b1;
    assign pslverr = apbAccess & ~hitAny;
    assign irq     = |(status & mask);

    // instruction-cycle dividers; only the source of the mode ticks
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            highCnt <= 7'h00;
            lowCnt  <= 3'h0;
            cpuTick <= 1'b0;
        end
        else
        begin
            if (highEdge)
                highCnt <= highWrap ? 7'h00 : highCnt + 7'h01;
            if (lowEdge)
                lowCnt <= lowWrap ? 3'h0 : lowCnt + 3'h1;
            cpuTick <= (modeNormal & highWrap) |           // [RULE_01]
                       (modeSlow & lowWrap);               // [RULE_03]
        end
    end

    // watchdog prescaler and counter; held at zero when disabled so
    // that turning it off can never leave a half-expired count
    always_ff @(posedge core_clk)
    begin
        if (srst | wdtOff)                                 // [RULE_07]
        begin
            wdtPreCnt <= 5'h00;
            wdtCnt    <= '0;
        end
        else if (wdtKick)
        begin
            wdtPreCnt <= 5'h00;
            wdtCnt    <= '0;
        end
        else if (wdtRun & lowEdge)                         // [RULE_05] [RULE_06]
        begin
            wdtPreCnt <= wdtPreWrap ? 5'h00 : wdtPreCnt + 5'h01; // [RULE_04]
            if (wdtPreWrap)
                wdtCnt <= wdtCnt + OCW_WDT_W'(1);
        end
    end

    // reset request, low-supply flags and shared pin drive
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            chipReset         <= 1'b0;
            lowSupplyFlagMid  <= 1'b0;
            lowSupplyFlagHigh <= 1'b0;
            flagMidPrev       <= 1'b0;
            flagHighPrev      <= 1'b0;
            sharedPinOut      <= 1'b0;
            sharedPinOe       <= 1'b0;
        end
        else
        begin
            chipReset         <= wdtFire | extResetEv | borEv; // [RULE_09] [RULE_12] [RULE_14]
            lowSupplyFlagMid  <= flagMid;                  // [RULE_13]
            lowSupplyFlagHigh <= flagHigh;                 // [RULE_15]
            flagMidPrev       <= flagMid;
            flagHighPrev      <= flagHigh;
            sharedPinOut      <= pinIsGpio & gpio[OCW_GPIO_OUT];
            sharedPinOe       <= pinIsGpio & gpio[OCW_GPIO_OE]; // [RULE_08]
        end
    end

    // readout gate: protected parts never show program words
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            readoutValid <= 1'b0;
            readoutData  <= 16'h0000;
        end
        else
        begin
            readoutValid <= readoutValidIn & ~opt.codeProtect; // [RULE_10] [RULE_11]
            readoutData  <= opt.codeProtect ? 16'h0000 : readoutDataIn;
        end
    end

    // apb register file
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            status <= '0;
            mask   <= OCW_MASK_RST;
            gpio   <= OCW_GPIO_RST;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            status <= next_status;
            if (wrEn & hitMask)
                mask <= pwdata[OCW_EV_W-1:0];
            if (wrEn & hitGpio)
                gpio <= pwdata[OCW_GPIO_OE:OCW_GPIO_OUT];
            if (apbSetup)
                prdata <= readMux;
        end
    end

endmodule // ocw_option_clock

// File: sim/ocw_option_clock_asserts.sv
// assertions on the ports of the option, clock and watchdog block
// assumes it is bound to the block's top and sees only its ports
module ocw_option_clock_asserts
    import ocw_pkg::*;
(
    // clock and reset
    input wire logic           core_clk,
    input wire logic           srst,
    // options and sources
    input wire ocw_option_type optionIn,
    input wire ocw_detect_type detectIn,
    input wire logic           readoutValidIn,
    input wire logic [15:0]    readoutDataIn,
    // observed outputs
    input wire logic           readoutValid,
    input wire logic [15:0]    readoutData,
    input wire logic           chipReset,
    input wire logic           lowSupplyFlagMid,
    input wire logic           lowSupplyFlagHigh,
    input wire logic           sharedPinOe
);
    timeunit 1ns;
    timeprecision 1ps;

    ocw_option_type opt;

    // own copy of the options, so a live input change cannot hide a slip
    always_ff @(posedge core_clk)
    begin
        if (srst)
            opt <= optionIn;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // eight cycles cover the detector synchroniser
    sequence s_low18;
        (opt.brownoutLevel == OCW_BOR_LOW && detectIn.below18)[*8];
    endsequence
    sequence s_high23;
        (opt.brownoutLevel == OCW_BOR_HIGH && detectIn.below23)[*8];
    endsequence
    sequence s_mid23;
        (opt.brownoutLevel == OCW_BOR_MID && detectIn.below23)[*8];
    endsequence
    sequence s_high30;
        (opt.brownoutLevel == OCW_BOR_HIGH && detectIn.below30)[*8];
    endsequence
    sequence s_quiet;
        (opt.watchdogPolicy == OCW_WDT_OFF && opt.sharedIoPinMode
            && detectIn == 3'h0)[*8];
    endsequence

    property p_bor_low;
        s_low18 |-> chipReset;
    endproperty
    property p_bor_high;
        s_high23 |-> chipReset;
    endproperty
    property p_flag_mid;
        s_mid23 |-> lowSupplyFlagMid;
    endproperty
    property p_mid_only;
        opt.brownoutLevel != OCW_BOR_MID |-> !lowSupplyFlagMid;
    endproperty
    property p_flag_high;
        s_high30 |-> lowSupplyFlagHigh;
    endproperty
    property p_quiet;
        s_quiet |-> !chipReset;
    endproperty
    property p_pin_oe;
        !opt.sharedIoPinMode |-> !sharedPinOe;
    endproperty
    property p_ro_pass;
        !opt.codeProtect && readoutValidIn
            |=> readoutValid && readoutData == $past(readoutDataIn);
    endproperty
    property p_ro_block;
        opt.codeProtect |=> !readoutValid && readoutData == 16'h0000;
    endproperty

    a_bor_low: assert property (p_bor_low)
        else $error("brown-out at low level gave no reset");
    a_bor_high: assert property (p_bor_high)
        else $error("brown-out at high level gave no reset");
    a_flag_mid: assert property (p_flag_mid)
        else $error("mid supply flag not set");
    a_mid_only: assert property (p_mid_only)
        else $error("mid supply flag set at another level");
    a_flag_high: assert property (p_flag_high)
        else $error("high supply flag not set");
    a_quiet: assert property (p_quiet)
        else $error("reset while all sources are off");
    a_pin_oe: assert property (p_pin_oe)
        else $error("shared pin driven in reset mode");
    a_ro_pass: assert property (p_ro_pass)
        else $error("readout not passed while unprotected");
    a_ro_block: assert property (p_ro_block)
        else $error("readout leaked while protected");
endmodule // ocw_option_clock_asserts

bind ocw_option_clock ocw_option_clock_asserts u_asserts (
    .core_clk          (core_clk),
    .srst              (srst),
    .optionIn          (optionIn),
    .detectIn          (detectIn),
    .readoutValidIn    (readoutValidIn),
    .readoutDataIn     (readoutDataIn),
    .readoutValid      (readoutValid),
    .readoutData       (readoutData),
    .chipReset         (chipReset),
    .lowSupplyFlagMid  (lowSupplyFlagMid),
    .lowSupplyFlagHigh (lowSupplyFlagHigh),
    .sharedPinOe       (sharedPinOe)
);

// File: sim/tb_ocw_option_clock.sv
// self-checking bench for the option, clock and watchdog block
// assumes a zero-wait apb slave and oscillators slower than core/8
module tb_ocw_option_clock
    import ocw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           core_clk, srst, psel, penable, pwrite, pready;
    logic           pslverr, irq, err, highOscIn, lowOscIn, sharedPinIn;
    logic           sharedPinOut, sharedPinOe, cpuTick, chipReset;
    logic           readoutValidIn, readoutValid;
    logic           lowSupplyFlagMid, lowSupplyFlagHigh;
    logic [1:0]     opMode;
    logic [7:0]     paddr;
    logic [15:0]    readoutDataIn, readoutData;
    logic [31:0]    pwdata, prdata, rd;
    ocw_option_type optionIn, base, o;
    ocw_detect_type detectIn;
    int             error_cnt, n_tests, nTick, nRst, n0;

    // watchdog table: policy, select, mode, firings over 1030 edges
    logic [1:0] wdPol [5] = '{OCW_WDT_ALWAYS, OCW_WDT_ALWAYS,
        OCW_WDT_ENABLE, OCW_WDT_ENABLE, OCW_WDT_OFF};
    logic [1:0] wdSel [5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
    logic [1:0] wdMode [5] = '{OCW_MODE_SLEEP, OCW_MODE_NORMAL,
        OCW_MODE_GREEN, OCW_MODE_SLOW, OCW_MODE_NORMAL};
    logic [31:0] wdExp [5] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h0};
    // brown-out table: level, detector, expected {reset, high, mid}
    logic [1:0] boLvl [4] = '{OCW_BOR_LOW, OCW_BOR_HIGH, OCW_BOR_MID,
        OCW_BOR_LOW};
    logic [2:0] boDet [4] = '{3'h1, 3'h6, 3'h2, 3'h6};
    logic [2:0] boExp [4] = '{3'h4, 3'h6, 3'h1, 3'h0};

    ocw_option_clock dut_u (
        .core_clk          (core_clk),
        .srst              (srst),
        .optionIn          (optionIn),
        .opMode            (opMode),
        .highOscIn         (highOscIn),
        .lowOscIn          (lowOscIn),
        .detectIn          (detectIn),
        .sharedPinIn       (sharedPinIn),
        .sharedPinOut      (sharedPinOut),
        .sharedPinOe       (sharedPinOe),
        .cpuTick           (cpuTick),
        .chipReset         (chipReset),
        .readoutValidIn    (readoutValidIn),
        .readoutDataIn     (readoutDataIn),
        .readoutValid      (readoutValid),
        .readoutData       (readoutData),
        .lowSupplyFlagMid  (lowSupplyFlagMid),
        .lowSupplyFlagHigh (lowSupplyFlagHigh),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .prdata            (prdata),
        .irq               (irq)
    );

    always #2 core_clk = ~core_clk;

    // pulse counters; tests take differences, so no second driver needed
    always @(posedge core_clk)
    begin
        nTick <= nTick + int'(cpuTick === 1'h1);
        nRst  <= nRst + int'(chipReset === 1'h1);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        k = 0;
        do @(posedge core_clk); while (pready !== 1'h1 && ++k < 50);
        // a slave that never answers ends the run as a failure
        if (pready !== 1'h1)
        begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // idle edge, so a following call never sets psel in this step
        @(posedge core_clk);
    endtask

    // options change after release to show they were caught in reset
    task automatic rst(input ocw_option_type v, input logic [1:0] m);
        optionIn <= v;
        opMode   <= m;
        srst     <= 1'h1;
        cyc(10);
        srst     <= 1'h0;
        cyc(1);
        optionIn <= ~v;
    endtask

    // n oscillator periods of ten core cycles, low or high oscillator
    task automatic osc(input logic lo, input int n);
        repeat (n)
        begin
            lowOscIn  <= lo;
            highOscIn <= !lo;
            cyc(5);
            lowOscIn  <= 1'h0;
            highOscIn <= 1'h0;
            cyc(5);
        end
        cyc(8);
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {highOscIn, lowOscIn, readoutValidIn, readoutDataIn} = '0;
        sharedPinIn = 1'h1;
        detectIn = 3'h0;
        base = '{3'h0, 2'h0, 2'h0, OCW_WDT_OFF, 1'h1, 1'h0, OCW_BOR_LOW};
        rst(base, OCW_MODE_NORMAL);
        apb(1'h0, OCW_OPTION_OFS, 32'h0);
        chk(rd, {19'h0, base});
        apb(1'h0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        // every normal and slow divider over a fixed number of edges
        for (int d = 0; d < 12; d++)
        begin
            o = base;
            o.highDiv = d[2:0];
            o.lowDiv = d[1:0];
            rst(o, (d < 8) ? OCW_MODE_NORMAL : OCW_MODE_SLOW);
            n0 = nTick;
            osc(d >= 8, 128);
            chk(32'(nTick - n0), 32'(128 >> d[2:0]));
        end
        // watchdog timeout is 1024 low edges at select 0
        for (int i = 0; i < 5; i++)
        begin
            o = base;
            o.watchdogPolicy = wdPol[i];
            o.watchdogClockSelect = wdSel[i];
            rst(o, wdMode[i]);
            n0 = nRst;
            osc(1'h1, 1030);
            chk(32'(nRst - n0), wdExp[i]);
        end
        // brown-out levels against detector patterns
        for (int i = 0; i < 4; i++)
        begin
            o = base;
            o.brownoutLevel = boLvl[i];
            rst(o, OCW_MODE_NORMAL);
            n0 = nRst;
            detectIn <= boDet[i];
            cyc(12);
            chk({29'h0, nRst != n0, lowSupplyFlagHigh, lowSupplyFlagMid},
                {29'h0, boExp[i]});
            detectIn <= 3'h0;
            cyc(12);
        end
        // readout passes unprotected, blanked when protected
        for (int p = 0; p < 2; p++)
        begin
            o = base;
            o.codeProtect = p[0];
            rst(o, OCW_MODE_NORMAL);
            readoutValidIn <= 1'h1;
            readoutDataIn  <= 16'hA5C3;
            cyc(3);
            chk({readoutValid, readoutData}, p ? 32'h0 : 32'h1A5C3);
            readoutValidIn <= 1'h0;
        end
        // gpio mode: pin driven by software, a fall does not reset
        rst(base, OCW_MODE_NORMAL);
        apb(1'h1, OCW_GPIO_OFS, 32'h3);
        cyc(2);
        chk({sharedPinOe, sharedPinOut}, 32'h3);
        n0 = nRst;
        sharedPinIn <= 1'h0;
        cyc(8);
        chk(32'(nRst - n0), 32'h0);
        // reset mode: a fall resets, raises a masked event, then clears
        sharedPinIn <= 1'h1;
        o = base;
        o.sharedIoPinMode = 1'h0;
        rst(o, OCW_MODE_NORMAL);
        // the synchroniser starts low, so let it see the pin high first
        cyc(4);
        n0 = nRst;
        sharedPinIn <= 1'h0;
        cyc(8);
        chk(32'(nRst - n0), 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, OCW_MASK_OFS, 32'h2);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'h0, OCW_STATUS_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'h1, OCW_STATUS_OFS, 32'h2);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        final_report();
    end

    // hang guard at 90k cycles, past the roughly 70k the tests need
    initial
    begin
        #360000;
        error_cnt++;
        final_report();
    end
endmodule // tb_ocw_option_clock
